// File: verilog/sdsk_pkg.sv
// package: opcodes, flag positions, reset values and cycle counts for the subtract/decrement unit
package sdsk_pkg;
   typedef enum logic [1:0] {
      SDSK_OP_NONE,
      SDSK_OP_SUB_BORROW_TO_MEM,
      SDSK_OP_DEC_SKIP_ZERO,
      SDSK_OP_DEC_TO_ACC_SKIP_ZERO
   } sdsk_op_t;
   localparam int FLAG_C_POS = 0;
   localparam int FLAG_AC_POS = 1;
   localparam int FLAG_Z_POS = 2;
   localparam int FLAG_OV_POS = 3;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [3:0] FLAGS_RESET = 4'h0;
   localparam logic [7:0] DEC_STEP = 8'h01;
   localparam int SKIP_CYCLES = 2;
   localparam int PLAIN_CYCLES = 1;
endpackage : sdsk_pkg

// File: verilog/sdsk_skip_ctl.sv
// skip controller: holds the dummy cycle that replaces a discarded fetched instruction
`timescale 1ns/1ps
`default_nettype none
module sdsk_skip_ctl (
   input wire logic clk,
   input wire logic rstn,
   input wire logic skipReq,
   output logic squash,
   output logic busy
);
   // a skip request is one cycle; the squash covers the following (dummy) cycle
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         squash <= 1'b0;
         busy <= 1'b0;
      end
      else
      begin
         squash <= skipReq;
         busy <= skipReq;
      end
   end
endmodule : sdsk_skip_ctl
`default_nettype wire

// File: verilog/sdsk_exec.sv
// execution unit for subtract-with-borrow-to-memory and the two decrement-and-skip ops
`timescale 1ns/1ps
`default_nettype none
module sdsk_exec (
   input wire logic clk,
   input wire logic rstn,
   input wire logic opValid,
   input wire sdsk_pkg::sdsk_op_t opCode,
   input wire logic [7:0] memRdata,
   input wire logic accLoad,
   input wire logic [7:0] accLoadData,
   output logic [7:0] accumulatorReg,
   output logic overflowFlag,
   output logic zeroFlag,
   output logic auxCarryFlag,
   output logic carryFlag,
   output logic memWe,
   output logic [7:0] memWdata,
   output logic skipTaken,
   output logic discardFetch,
   output logic opDone
);
   logic squash;
   logic busy;

   // an op issued during the dummy cycle is the discarded fetch and never executes
   wire issue = opValid && !squash;
   wire isSub = issue && (opCode == sdsk_pkg::SDSK_OP_SUB_BORROW_TO_MEM);
   wire isDecMem = issue && (opCode == sdsk_pkg::SDSK_OP_DEC_SKIP_ZERO);
   wire isDecAcc = issue && (opCode == sdsk_pkg::SDSK_OP_DEC_TO_ACC_SKIP_ZERO);

   // subtract as acc + ~m + c so carry set means no borrow
   wire [7:0] memInv = ~memRdata;
   wire [8:0] subSum = {1'b0, accumulatorReg} + {1'b0, memInv} + {8'h00, carryFlag};
   wire [4:0] lowSum = {1'b0, accumulatorReg[3:0]} + {1'b0, memInv[3:0]}
      + {4'h0, carryFlag};
   wire [7:0] subRes = subSum[7:0];
   // signed overflow: like-signed addends giving a result of the other sign
   wire subOv = (accumulatorReg[7] == memInv[7]) && (subRes[7] != accumulatorReg[7]);
   // zero wraps to FF naturally, which is nonzero and therefore never skips
   wire [7:0] decRes = memRdata - sdsk_pkg::DEC_STEP;
   // one compare serves both decrement ops, so their skip decisions cannot drift apart
   wire decZero = (decRes == 8'h00);
   wire skipNow = (isDecMem || isDecAcc) && decZero;

   wire [7:0] next_acc = isDecAcc ? decRes : (accLoad ? accLoadData : accumulatorReg);
   wire next_memWe = isSub || isDecMem;
   wire [7:0] next_memWdata = isSub ? subRes : decRes;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         accumulatorReg <= sdsk_pkg::ACC_RESET;
         {overflowFlag, zeroFlag, auxCarryFlag, carryFlag} <= sdsk_pkg::FLAGS_RESET;
      end
      else
      begin
         accumulatorReg <= next_acc;
         if (isSub)
         begin
            overflowFlag <= subOv;
            zeroFlag <= (subRes == 8'h00);
            auxCarryFlag <= lowSum[4];
            carryFlag <= subSum[8];
         end
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         memWe <= 1'b0;
         memWdata <= 8'h00;
         skipTaken <= 1'b0;
         opDone <= 1'b0;
      end
      else
      begin
         memWe <= next_memWe;
         memWdata <= next_memWdata;
         skipTaken <= skipNow;
         // ops complete in one cycle unless a skip adds the dummy cycle
         opDone <= (issue && !skipNow) || busy;
      end
   end

   // the dummy cycle lives in its own small controller so the squash stays one register
   sdsk_skip_ctl u_skip (
      .clk(clk),
      .rstn(rstn),
      .skipReq(skipNow),
      .squash(squash),
      .busy(busy)
   );

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         discardFetch <= 1'b0;
      else
         discardFetch <= skipNow;
   end

   property p_sub_write;
      @(posedge clk) disable iff (!rstn)
      isSub |=> memWe && memWdata == 8'($past(accumulatorReg) + ~$past(memRdata)
         + {7'h00, $past(carryFlag)});
   endproperty
   a_sub_write: assert property (p_sub_write) else $error("sub result not written");

   property p_sub_carry;
      @(posedge clk) disable iff (!rstn)
      isSub |=> zeroFlag == (memWdata == 8'h00)
         && carryFlag == ($past(accumulatorReg) > $past(memRdata)
         || ($past(accumulatorReg) == $past(memRdata) && $past(carryFlag)));
   endproperty
   a_sub_carry: assert property (p_sub_carry) else $error("sub flags wrong");

   property p_dec_write;
      @(posedge clk) disable iff (!rstn)
      isDecMem |=> memWe && memWdata == $past(memRdata) - 8'h01;
   endproperty
   a_dec_write: assert property (p_dec_write) else $error("decrement not written");

   sequence s_skip;
      skipNow ##1 squash;
   endsequence
   property p_skip_two;
      @(posedge clk) disable iff (!rstn)
      skipNow |-> s_skip ##1 opDone;
   endproperty
   a_skip_two: assert property (p_skip_two) else $error("skip not two cycles");

   property p_plain_one;
      @(posedge clk) disable iff (!rstn)
      issue && !skipNow |=> opDone && !discardFetch;
   endproperty
   a_plain_one: assert property (p_plain_one) else $error("plain op not one cycle");

   property p_dec_acc;
      @(posedge clk) disable iff (!rstn)
      isDecAcc |=> accumulatorReg == $past(memRdata) - 8'h01 && skipTaken == (accumulatorReg == 0);
   endproperty
   a_dec_acc: assert property (p_dec_acc) else $error("acc decrement wrong");

   property p_acc_nomem;
      @(posedge clk) disable iff (!rstn)
      isDecAcc |=> !memWe;
   endproperty
   a_acc_nomem: assert property (p_acc_nomem) else $error("memory written by acc op");

   property p_wrap;
      @(posedge clk) disable iff (!rstn)
      (isDecMem || isDecAcc) && memRdata == 8'h00 |=> !skipTaken && !squash;
   endproperty
   a_wrap: assert property (p_wrap) else $error("zero wrap skipped");

   // flag checks use compares of the operands, not the datapath wires, so a slip there shows
   property p_sub_aux;
      @(posedge clk) disable iff (!rstn)
      isSub |=> auxCarryFlag == ($past(accumulatorReg[3:0]) > $past(memRdata[3:0])
         || ($past(accumulatorReg[3:0]) == $past(memRdata[3:0]) && $past(carryFlag)));
   endproperty
   a_sub_aux: assert property (p_sub_aux) else $error("sub aux carry wrong");

   // operands of unlike sign and a result whose sign left the accumulator's
   property p_sub_ov;
      @(posedge clk) disable iff (!rstn)
      isSub |=> overflowFlag == (($past(accumulatorReg[7]) != $past(memRdata[7]))
         && (memWdata[7] != $past(accumulatorReg[7])));
   endproperty
   a_sub_ov: assert property (p_sub_ov) else $error("sub overflow wrong");

   // only the subtract touches the status flags
   property p_flags_hold;
      @(posedge clk) disable iff (!rstn)
      !isSub |=> $stable({overflowFlag, zeroFlag, auxCarryFlag, carryFlag});
   endproperty
   a_flags_hold: assert property (p_flags_hold) else $error("flags moved without sub");

   // the subtract result goes to memory, so the accumulator must not move with it
   property p_acc_hold;
      @(posedge clk) disable iff (!rstn)
      !isDecAcc && !accLoad |=> $stable(accumulatorReg);
   endproperty
   a_acc_hold: assert property (p_acc_hold) else $error("accumulator moved");

   // the decrement wins over an outside load in the same cycle
   property p_acc_load;
      @(posedge clk) disable iff (!rstn)
      accLoad && !isDecAcc |=> accumulatorReg == $past(accLoadData);
   endproperty
   a_acc_load: assert property (p_acc_load) else $error("accumulator load lost");

   // a byte of one decrements to zero: marks first, then done with the dummy cycle quiet
   sequence s_dec_to_zero;
      (isDecMem || isDecAcc) && memRdata == 8'h01;
   endsequence
   sequence s_skip_mark;
      skipTaken && discardFetch && !opDone;
   endsequence
   property p_skip_marks;
      @(posedge clk) disable iff (!rstn)
      s_dec_to_zero |=> s_skip_mark ##1 (opDone && !memWe);
   endproperty
   a_skip_marks: assert property (p_skip_marks) else $error("skip not signalled");

   // any other byte leaves a nonzero result, which completes in one cycle
   property p_dec_noskip;
      @(posedge clk) disable iff (!rstn)
      (isDecMem || isDecAcc) && memRdata != 8'h01 |=> !skipTaken && !discardFetch && opDone;
   endproperty
   a_dec_noskip: assert property (p_dec_noskip) else $error("decrement skipped");

   // an op offered in the dummy cycle is the discarded fetch: no write, no new skip
   property p_squash_ignore;
      @(posedge clk) disable iff (!rstn)
      squash |=> !memWe && !skipTaken && !discardFetch;
   endproperty
   a_squash_ignore: assert property (p_squash_ignore) else $error("discarded op ran");
endmodule : sdsk_exec
`default_nettype wire

// File: bench/sdsk_exec_tb.sv
// self-checking bench for the subtract and decrement-skip execution unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam sdsk_pkg::sdsk_op_t SUB = sdsk_pkg::SDSK_OP_SUB_BORROW_TO_MEM;
   localparam sdsk_pkg::sdsk_op_t DSK = sdsk_pkg::SDSK_OP_DEC_SKIP_ZERO;
   localparam sdsk_pkg::sdsk_op_t DAC = sdsk_pkg::SDSK_OP_DEC_TO_ACC_SKIP_ZERO;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic opValid = 1'b0;
   logic accLoad = 1'b0;
   sdsk_pkg::sdsk_op_t opCode = sdsk_pkg::SDSK_OP_NONE;
   logic [7:0] memRdata = 8'h00;
   logic [7:0] accLoadData = 8'h00;
   logic [7:0] accumulatorReg, memWdata;
   logic overflowFlag, zeroFlag, auxCarryFlag, carryFlag, memWe, skipTaken, discardFetch, opDone;
   int failures = 0, numChecks = 0, cyc = 0;
   int acc = 0, c = 0, ov = 0, z = 0, ac = 0;
   always #10 clk = ~clk;
   sdsk_exec dut (.clk(clk), .rstn(rstn), .opValid(opValid), .opCode(opCode),
      .memRdata(memRdata), .accLoad(accLoad), .accLoadData(accLoadData),
      .accumulatorReg(accumulatorReg), .overflowFlag(overflowFlag), .zeroFlag(zeroFlag),
      .auxCarryFlag(auxCarryFlag), .carryFlag(carryFlag), .memWe(memWe), .memWdata(memWdata),
      .skipTaken(skipTaken), .discardFetch(discardFetch), .opDone(opDone));
   task automatic end_sim;
      $display("checks %0d failures %0d", numChecks, failures);
      if (failures == 0 && numChecks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   task automatic chk(logic [7:0] g, logic [7:0] e, string m);
      numChecks++;
      if (g !== e)
      begin
         failures++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk
   task automatic ld(int v);
      @(posedge clk) accLoad <= 1'b1;
      accLoadData <= 8'(v);
      @(posedge clk) accLoad <= 1'b0;
      acc = v;
   endtask : ld
   // poke presents an op in the dummy cycle, which must be ignored
   task automatic issue(sdsk_pkg::sdsk_op_t op, int m, bit poke);
      int r, s, sk, we;
      r = (m - 1) & 255;
      sk = 0;
      we = 1;
      if (op == SUB)
      begin
         s = acc + (~m & 255) + c;
         r = s & 255;
         ac = ((acc & 15) + (~m & 15) + c) >> 4;
         ov = (((acc ^ r) & (acc ^ m)) >> 7) & 1;
         c = s >> 8;
         z = (r == 0);
      end
      else
      begin
         sk = (r == 0);
         if (op == DAC)
         begin
            acc = r;
            we = 0;
         end
      end
      @(posedge clk) opValid <= 1'b1;
      opCode <= op;
      memRdata <= 8'(m);
      @(posedge clk) opValid <= poke;
      opCode <= SUB;
      #1 chk(memWe, 8'(we), "write");
      if (we) chk(memWdata, 8'(r), "wdata");
      chk(accumulatorReg, 8'(acc), "acc");
      chk({overflowFlag, zeroFlag, auxCarryFlag, carryFlag}, 8'(ov*8+z*4+ac*2+c), "flags");
      chk({skipTaken, discardFetch, opDone}, 8'(sk*6+1-sk), "skip");
      @(posedge clk) opValid <= 1'b0;
      #1 chk({memWe, opDone}, 8'(sk), "dummy");
   endtask : issue
   always @(posedge clk)
   begin
      cyc++;
      if (cyc > 2000)
      begin
         failures++;
         end_sim();
      end
   end
   initial
   begin
      void'($urandom(50));
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      issue(DSK, 1, 1);
      issue(DSK, 0, 0);
      issue(DAC, 1, 1);
      issue(DAC, 0, 0);
      ld(5);
      issue(SUB, 3, 0);
      ld(8'h7F);
      issue(SUB, 8'h80, 0);
      repeat (80)
      begin
         if ($urandom_range(1)) ld($urandom_range(255));
         issue(sdsk_pkg::sdsk_op_t'($urandom_range(3, 1)), $urandom_range(255), 0);
      end
      end_sim();
   end
endmodule : testbench
`default_nettype wire
